// >>> core/agrc_pkg.sv
// Constants and types for the gain, rate and calibration register block
`default_nettype none
package agrc_pkg;
    localparam logic [7:0] ADDR_GAIN_RATE  = 8'h03;
    localparam logic [7:0] ADDR_OFS_LOW    = 8'h04;
    localparam logic [7:0] ADDR_OFS_MID    = 8'h05;
    localparam logic [7:0] ADDR_OFS_HIGH   = 8'h06;
    localparam logic [7:0] ADDR_SCL_LOW    = 8'h07;
    localparam logic [7:0] ADDR_SCL_MID    = 8'h08;
    localparam logic [7:0] ADDR_SCL_HIGH   = 8'h09;
    localparam logic [7:0] ADDR_EXC_READY  = 8'h0A;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h11;
    localparam logic [7:0] GAIN_RATE_RST   = 8'h00;
    localparam logic [7:0] SCL_HIGH_RST    = 8'h40;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;
    localparam logic [3:0] REVISION_VALUE  = 4'h1; // Arbitrary value
    localparam logic [2:0] MON_NORMAL      = 3'h0;
    localparam logic [2:0] MON_OFFSET      = 3'h1;
    localparam logic [2:0] GAIN_UNITY      = 3'h0;
    localparam int         SCALE_SHIFT     = 22;   // 400000h = 2**22
    localparam logic [3:0] RATE_1000_CODE  = 4'h8;
    localparam int         IRQ_BITS        = 3;
    localparam int         IRQ_RESULT      = 0;
    localparam int         IRQ_ODD_MAG     = 1;
    localparam int         IRQ_SAT         = 2;
    localparam logic [2:0] MAG_ODD_A       = 3'h5;
    localparam logic [2:0] MAG_ODD_B       = 3'h7;
    typedef enum logic [1:0] {AGRC_IDLE, AGRC_SUB, AGRC_MUL, AGRC_OUT}
        agrc_state_t;
endpackage
`default_nettype wire

// >>> core/agrc_regs.sv
// Gain, rate, calibration and excitation registers with result correction
//
// Design decision made here: the plain strobed port.
`default_nettype none
module agrc_regs #(
    parameter int RAW_W = 24
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    // Monitor selection from the reference control logic
    input  wire logic [2:0]             system_monitor_select,
    // Decoded settings
    output logic      [7:0]             gain_value,
    output logic      [11:0]            rate_sps,
    output logic      [2:0]             current_magnitude,
    output logic                        ready_on_output_pin,
    // Conversion path
    input  wire logic                   raw_valid,
    input  wire logic signed [RAW_W-1:0] raw_result,
    output logic signed [RAW_W-1:0]     corrected_result,
    output logic                        corrected_valid,
    // Pins
    input  wire logic                   serial_data_bit,
    input  wire logic                   transfer_active,
    input  wire logic                   result_taken,
    output logic                        shared_serial_output_pin,
    output logic                        result_ready_pin_n,
    output logic                        irq
);
    import agrc_pkg::*;

    logic [6:0]  gain_rate_r;
    logic [23:0] offset_coefficient_r;
    logic [23:0] scale_coefficient_r;
    logic        ready_mode_r;
    logic [2:0]  magnitude_r;
    logic [IRQ_BITS-1:0] status_r;
    logic [IRQ_BITS-1:0] mask_r;
    logic [IRQ_BITS-1:0] ev;
    logic        pending_r;
    agrc_state_t state_r;
    logic signed [RAW_W+1:0] diff_r;
    logic signed [RAW_W+26:0] prod_r;
    logic signed [RAW_W+26:0] shifted;
    logic signed [RAW_W-1:0] max_v;
    logic signed [RAW_W-1:0] min_v;
    logic        sat;

    // Gain code to amplifier gain
    function automatic logic [7:0] gain_of(input logic [2:0] code);
        gain_of = 8'h01 << code;
    endfunction

    // Register writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gain_rate_r          <= GAIN_RATE_RST[6:0];
            offset_coefficient_r <= {BYTE_ZERO, BYTE_ZERO, BYTE_ZERO};
            scale_coefficient_r  <= {SCL_HIGH_RST, BYTE_ZERO, BYTE_ZERO};
            ready_mode_r         <= 1'b0;
            magnitude_r          <= 3'h0;
            mask_r               <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_GAIN_RATE: gain_rate_r <= reg_wdata[6:0];
                // Offset low byte at first address
                ADDR_OFS_LOW:  offset_coefficient_r[7:0]   <= reg_wdata;
                ADDR_OFS_MID:  offset_coefficient_r[15:8]  <= reg_wdata;
                ADDR_OFS_HIGH: offset_coefficient_r[23:16] <= reg_wdata;
                // Scale high byte at last address
                ADDR_SCL_LOW:  scale_coefficient_r[7:0]    <= reg_wdata;
                ADDR_SCL_MID:  scale_coefficient_r[15:8]   <= reg_wdata;
                ADDR_SCL_HIGH: scale_coefficient_r[23:16]  <= reg_wdata;
                ADDR_EXC_READY: begin
                    ready_mode_r <= reg_wdata[3];   // Bits 7:4 dropped
                    magnitude_r  <= reg_wdata[2:0];
                end
                ADDR_IRQ_MASK: mask_r <= reg_wdata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= BYTE_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_GAIN_RATE: reg_rdata <= {1'b0, gain_rate_r};
                ADDR_OFS_LOW:   reg_rdata <= offset_coefficient_r[7:0];
                ADDR_OFS_MID:   reg_rdata <= offset_coefficient_r[15:8];
                ADDR_OFS_HIGH:  reg_rdata <= offset_coefficient_r[23:16];
                ADDR_SCL_LOW:   reg_rdata <= scale_coefficient_r[7:0];
                ADDR_SCL_MID:   reg_rdata <= scale_coefficient_r[15:8];
                ADDR_SCL_HIGH:  reg_rdata <= scale_coefficient_r[23:16];
                ADDR_EXC_READY: reg_rdata <= {REVISION_VALUE, ready_mode_r,
                                              magnitude_r};
                ADDR_IRQ_STATUS: reg_rdata <= {{(8-IRQ_BITS){1'b0}}, status_r};
                ADDR_IRQ_MASK:   reg_rdata <= {{(8-IRQ_BITS){1'b0}}, mask_r};
                default:        reg_rdata <= BYTE_ZERO;
            endcase
        end else begin
            reg_rdata <= BYTE_ZERO;
        end
    end

    // Gain with monitor override
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gain_value <= gain_of(GAIN_UNITY);
        end else if (system_monitor_select != MON_NORMAL &&
                     system_monitor_select != MON_OFFSET) begin
            gain_value <= gain_of(GAIN_UNITY);
        end else begin
            gain_value <= gain_of(gain_rate_r[6:4]);
        end
    end

    // Rate code to samples per second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rate_sps <= 12'h005;
        end else begin
            case (gain_rate_r[3:0])
                4'h0: rate_sps <= 12'h005;
                4'h1: rate_sps <= 12'h00A;
                4'h2: rate_sps <= 12'h014;
                4'h3: rate_sps <= 12'h028;
                4'h4: rate_sps <= 12'h050;
                4'h5: rate_sps <= 12'h0A0;
                4'h6: rate_sps <= 12'h140;
                4'h7: rate_sps <= 12'h280;
                RATE_1000_CODE: rate_sps <= 12'h3E8;
                default: rate_sps <= 12'h7D0;
            endcase
        end
    end

    // Excitation and pin mode outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            current_magnitude   <= 3'h0;
            ready_on_output_pin <= 1'b0;
        end else begin
            current_magnitude   <= magnitude_r; // Odd codes passed
            ready_on_output_pin <= ready_mode_r;
        end
    end

    // Correction: subtract, scale, saturate
    assign shifted = prod_r >>> SCALE_SHIFT;
    assign max_v   = {1'b0, {(RAW_W-1){1'b1}}};
    assign min_v   = {1'b1, {(RAW_W-1){1'b0}}};
    assign sat     = (shifted > $signed({{27{1'b0}}, max_v})) ||
                     (shifted < $signed({{27{1'b1}}, min_v}));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r          <= AGRC_IDLE;
            diff_r           <= '0;
            prod_r           <= '0;
            corrected_result <= '0;
            corrected_valid  <= 1'b0;
        end else begin
            corrected_valid <= 1'b0;
            case (state_r)
                AGRC_IDLE: if (raw_valid) state_r <= AGRC_SUB;
                AGRC_SUB: begin
                    // Offset low byte is sub-LSB
                    diff_r  <= $signed({{2{raw_result[RAW_W-1]}}, raw_result})
                             - $signed({{2{offset_coefficient_r[23]}},
                                        offset_coefficient_r[23:8]});
                    state_r <= AGRC_MUL;
                end
                AGRC_MUL: begin
                    prod_r  <= diff_r * $signed({1'b0, scale_coefficient_r});
                    state_r <= AGRC_OUT;
                end
                AGRC_OUT: begin
                    corrected_result <= sat ? (shifted[RAW_W+26] ? min_v : max_v)
                                            : shifted[RAW_W-1:0];
                    corrected_valid  <= 1'b1;
                    state_r          <= AGRC_IDLE;
                end
                default: state_r <= AGRC_IDLE;
            endcase
        end
    end

    // Result pending until taken, set wins
    always_ff @(posedge clk) begin
        if (sys_rst) pending_r <= 1'b0;
        else if (corrected_valid) pending_r <= 1'b1;
        else if (result_taken) pending_r <= 1'b0;
    end

    // Ready pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_ready_pin_n       <= 1'b1;
            shared_serial_output_pin <= 1'b1;
        end else begin
            result_ready_pin_n <= ~pending_r;
            if (transfer_active || !ready_mode_r)
                shared_serial_output_pin <= serial_data_bit;
            else
                shared_serial_output_pin <= ~pending_r;
        end
    end

    // Sticky status, cleared by read, set wins
    assign ev[IRQ_RESULT]  = corrected_valid;
    assign ev[IRQ_ODD_MAG] = (magnitude_r == MAG_ODD_A) ||
                             (magnitude_r == MAG_ODD_B);
    assign ev[IRQ_SAT]     = (state_r == AGRC_OUT) && sat;

    always_ff @(posedge clk) begin
        if (sys_rst) status_r <= '0;
        else if (reg_rd && reg_addr == ADDR_IRQ_STATUS) status_r <= ev;
        else status_r <= status_r | ev;
    end

    assign irq = |(status_r & mask_r);
endmodule
`default_nettype wire

// >>> tb/agrc_regs_checker.sv
// Port-level assertions for the gain, rate and calibration registers
`default_nettype none
module agrc_regs_checker (
    // Clock, reset and register port
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Settings, conversion path and pins
    input wire logic [2:0] system_monitor_select,
    input wire logic [7:0] gain_value,
    input wire logic       ready_on_output_pin,
    input wire logic       raw_valid,
    input wire logic       corrected_valid,
    input wire logic       serial_data_bit,
    input wire logic       shared_serial_output_pin,
    input wire logic       result_ready_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import agrc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Register reads, gain forcing, result timing and pin behaviour
    a_reserved_bit_zero: assert property (reg_rd && reg_addr == ADDR_GAIN_RATE
        |=> !reg_rdata[7]) else $error("reserved bit read as one");
    a_revision_fixed: assert property (reg_rd && reg_addr == ADDR_EXC_READY
        |=> reg_rdata[7:4] == REVISION_VALUE) else $error("revision moved");
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_gain_power_two: assert property ($onehot(gain_value))
        else $error("gain not a power of two");
    a_gain_forced_one: assert property (system_monitor_select > MON_OFFSET
        |=> gain_value == 8'h01) else $error("gain not forced");
    a_result_latency: assert property (raw_valid |-> ##[3:4] corrected_valid)
        else $error("result late");
    a_valid_one_cycle: assert property (corrected_valid |=> !corrected_valid)
        else $error("valid too long");
    a_ready_pin_low: assert property (corrected_valid
        |-> ##[1:2] !result_ready_pin_n) else $error("ready pin idle");
    // Pin and mode copy both load on the same edge, so compare in one cycle
    a_data_only_mode: assert property (!ready_on_output_pin && !$past(sys_rst)
        |-> shared_serial_output_pin == $past(serial_data_bit))
        else $error("shared pin not data");
endmodule
`default_nettype wire

// >>> tb/agrc_host_model.sv
// Host model that frames a transfer once a result is flagged
`default_nettype none
module agrc_host_model (
    // Clock and control
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic take_en,
    // Device pins
    input wire logic result_ready_pin_n,
    output logic     transfer_active,
    output logic     serial_data_bit,
    output logic     result_taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] bit_cnt_r;
    logic       done_r;
    // Data line changes every cycle so a stale value never matches
    always_ff @(posedge clk) begin
        serial_data_bit <= sys_rst ? 1'b0 : ~serial_data_bit;
    end
    // Eight-cycle frame, then acknowledge; wait for the pin to clear
    always_ff @(posedge clk) begin
        result_taken <= 1'b0;
        if (sys_rst) begin
            transfer_active <= 1'b0;
            bit_cnt_r       <= 3'h0;
            done_r          <= 1'b0;
        end else if (transfer_active) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
                transfer_active <= 1'b0;
                result_taken    <= 1'b1;
                done_r          <= 1'b1;
            end
        end else if (done_r) begin
            done_r <= ~result_ready_pin_n;
        end else if (take_en && !result_ready_pin_n) begin
            transfer_active <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> tb/adc_gain_rate_calibration_regs_bench.sv
// Self-checking bench for the gain, rate and calibration registers
`default_nettype none
module adc_gain_rate_calibration_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import agrc_pkg::*;
    logic clk, sys_rst, reg_wr, reg_rd, raw_valid, corrected_valid, irq;
    logic serial_data_bit, transfer_active, result_taken, take_en;
    logic shared_serial_output_pin, result_ready_pin_n, ready_on_output_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, gain_value, d;
    logic [2:0] system_monitor_select, current_magnitude;
    logic [11:0] rate_sps;
    logic signed [23:0] raw_result, corrected_result;
    int failures, samples_checked, i;
    int sps_tab[16] = '{5, 10, 20, 40, 80, 160, 320, 640, 1000,
                        2000, 2000, 2000, 2000, 2000, 2000, 2000};
    agrc_regs uut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .system_monitor_select, .gain_value, .rate_sps,
        .current_magnitude, .ready_on_output_pin, .raw_valid, .raw_result,
        .corrected_result, .corrected_valid, .serial_data_bit,
        .transfer_active, .result_taken, .shared_serial_output_pin,
        .result_ready_pin_n, .irq);
    agrc_host_model host (.clk, .sys_rst, .take_en, .result_ready_pin_n,
        .transfer_active, .serial_data_bit, .result_taken);
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %0h saw %0h", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic conv(logic signed [23:0] raw, logic signed [23:0] e);
        int n;
        @(posedge clk);
        raw_result <= raw;
        raw_valid  <= 1'b1;
        @(posedge clk);
        raw_valid <= 1'b0;
        for (n = 0; n < 10 && corrected_valid !== 1'b1; n++)
            @(posedge clk) #1;
        chk("result", corrected_result, e);
    endtask
    task automatic t_reset_vals;
        for (i = 3; i < 10; i++) begin
            rd(8'(i));
            chk("reset", d, (i == 9) ? 8'h40 : 8'h00);
        end
        rd(ADDR_EXC_READY);
        chk("exc_reset", d, {REVISION_VALUE, 4'h0});
        rd(8'h30);
        chk("unmapped", d, 8'h00);
    endtask
    task automatic t_gain_rate;
        for (i = 0; i < 16; i++) begin
            wr(ADDR_GAIN_RATE, {1'b1, i[2:0], i[3:0]});
            rd(ADDR_GAIN_RATE);
            chk("gain_rate", d, {1'b0, i[2:0], i[3:0]});
            chk("gain", gain_value, 8'h01 << i[2:0]);
            chk("rate", rate_sps, sps_tab[i]);
        end
        @(posedge clk);
        system_monitor_select <= 3'h2;
        repeat (2) @(posedge clk) #1;
        chk("forced", gain_value, 8'h01);
        @(posedge clk);
        system_monitor_select <= 3'h1;
        repeat (2) @(posedge clk) #1;
        chk("restored", gain_value, 8'h80);
    endtask
    task automatic t_excite;
        // Reference taken as switched on before nonzero magnitudes
        for (i = 0; i < 8; i++) begin
            wr(ADDR_EXC_READY, {5'h00, i[2:0]});
            @(posedge clk) #1;
            chk("mag", current_magnitude, i[2:0]);
        end
        chk("masked", irq, 1'b0);
        wr(ADDR_IRQ_MASK, 8'h02);
        wr(ADDR_EXC_READY, 8'hFD);
        rd(ADDR_EXC_READY);
        chk("exc", d, {REVISION_VALUE, 4'hD});
        chk("irq_on", irq, 1'b1);
        wr(ADDR_EXC_READY, 8'h08);
        rd(ADDR_IRQ_STATUS);
        rd(ADDR_IRQ_STATUS);
        chk("cleared", {d[1], irq}, 2'b00);
    endtask
    task automatic t_correct;
        conv(-24'sd5, -24'sd5);
        wr(ADDR_OFS_LOW, 8'hFF);
        wr(ADDR_OFS_MID, 8'h01);
        wr(ADDR_SCL_HIGH, 8'h20);
        conv(24'sd1001, 24'sd500);
        wr(ADDR_OFS_MID, 8'hFF);
        wr(ADDR_OFS_HIGH, 8'hFF);
        conv(24'sd9, 24'sd5);
        wr(ADDR_SCL_HIGH, 8'hFF);
        conv(24'sh400000, 24'sh7FFFFF);
        rd(ADDR_IRQ_STATUS);
        chk("status", d, 8'h05);
        repeat (3) @(posedge clk) #1;
        chk("pins", {result_ready_pin_n, shared_serial_output_pin}, 2'b00);
        @(posedge clk);
        take_en <= 1'b1;
        for (i = 0; i < 30 && result_taken !== 1'b1; i++)
            @(posedge clk) #1;
        repeat (3) @(posedge clk) #1;
        chk("taken", result_ready_pin_n, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000 failures++;
        tally_and_finish;
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, raw_valid, take_en} = 5'h10;
        {reg_addr, reg_wdata, system_monitor_select, raw_result} = '0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset_vals;
        t_gain_rate;
        t_excite;
        t_correct;
        tally_and_finish;
    end
endmodule
bind agrc_regs agrc_regs_checker chk_i (.clk, .sys_rst, .reg_addr, .reg_rd,
    .reg_rdata, .system_monitor_select, .gain_value, .ready_on_output_pin,
    .raw_valid, .corrected_valid, .serial_data_bit,
    .shared_serial_output_pin, .result_ready_pin_n);
`default_nettype wire
